// ---- bench/csp_csv_core_properties.sv ----
// Port checker for the cyclic synchronous position / velocity core.
// Assumes a bind from tb_top; one clock domain, reset rstn.
`timescale 1ns/1ps
`default_nettype none
module csp_csv_core_properties #(
  parameter int MS_CYCLES = 40000
) (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire csp_csv_pkg::bus_req_type busReq,
  input wire logic [31:0]              busRdata,
  input wire logic                     syncPulse,
  input wire logic                     limitPosPin,
  input wire logic                     limitNegPin,
  input wire csp_csv_pkg::drive_type   actual,
  input wire csp_csv_pkg::drive_type   demand,
  input wire logic                     demandValid,
  input wire logic                     quickStopActive
);
  // Sync drops within three 1 ms periods; margin covers the pin path
  localparam int LOSS_MAX = 3 * MS_CYCLES + 100;
  logic [19:0] sinceSync;
  ////////////////////////////////////////////////
  // Cycles since the sync pin was last seen high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sinceSync <= 20'hfffff;
    end else if (syncPulse) begin
      sinceSync <= 20'h0;
    end else if (sinceSync != 20'hfffff) begin
      sinceSync <= sinceSync + 20'h1;
    end
  end
  // Magnitude of a signed speed
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? -v : v;
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!busReq.rd |=> busRdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_pos_needs_sync: assert property (!quickStopActive && $changed(demand.pos) |-> sinceSync <= 20'h8)
    else $error("demand position moved without a sync edge");
  a_vel_needs_sync: assert property (!quickStopActive && !$past(quickStopActive)
    && $changed(demand.vel) |-> sinceSync <= 20'h8)
    else $error("demand speed moved without a sync edge");
  a_valid_needs_sync: assert property (demandValid |-> sinceSync <= LOSS_MAX)
    else $error("following flagged long after sync stopped");
  a_qs_brakes_down: assert property (quickStopActive && $past(quickStopActive)
    |-> mag(demand.vel) <= mag($past(demand.vel)))
    else $error("speed grew during quick stop");
  a_qs_not_follow: assert property (quickStopActive [*4] |-> !demandValid)
    else $error("presets followed during quick stop");
  a_hold_between: assert property ((!syncPulse && !quickStopActive) [*6] |=> $stable(demand.pos))
    else $error("demand position changed between cycles");
  a_limit_no_advance: assert property (limitPosPin [*6] |=> demand.pos <= $past(demand.pos))
    else $error("demand moved into a tripped positive limit");
  c_follow: cover property (demandValid ##1 syncPulse);
  c_qstop: cover property (quickStopActive ##1 !quickStopActive);
  c_limit: cover property (limitPosPin && demandValid);
endmodule
`default_nettype wire

// ---- bench/motion_ctrl_model.sv ----
// Model of the outside motion controller and the axis it drives.
// Assumes the bench owns the register port; this side makes sync and feedback.
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model #(
  parameter int SYNC_GAP = 200
) (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   syncOn,
  input  wire logic signed [31:0]     feOffset,
  input  wire csp_csv_pkg::drive_type demand,
  output logic                        syncPulse,
  output csp_csv_pkg::drive_type      actual
);
  logic [15:0] phase;
  ////////////////////////////////////////////////
  // Two-cycle sync pulse at a fixed period; pin rests low when switched off
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase     <= 16'h0;
      syncPulse <= 1'b0;
    end else begin
      phase     <= (phase == 16'(SYNC_GAP - 1)) ? 16'h0 : phase + 16'h1;
      syncPulse <= syncOn && (phase < 16'h2);
    end
  end
  // Axis tracks demand, with an injected position offset to provoke following errors
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      actual <= '0;
    end else begin
      actual.pos <= demand.pos + feOffset;
      actual.vel <= demand.vel;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the cyclic synchronous position / velocity core.
// Assumes the core, its package, its constants header and the partner model.
`timescale 1ns/1ps
`include "csp_csv_consts.svh"
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  logic                      core_clk;
  logic                      rstn;
  csp_csv_pkg::bus_req_type  busReq;
  logic [31:0]               busRdata;
  logic                      syncPulse;
  logic                      limitPosPin;
  logic                      limitNegPin;
  logic                      syncOn;
  logic signed [31:0]        feOffset;
  csp_csv_pkg::drive_type    actual;
  csp_csv_pkg::drive_type    demand;
  logic                      demandValid;
  logic                      quickStopActive;
  int                        err_total;
  int                        n_tests;
  // Short millisecond keeps the run brief; the partner syncs once per millisecond
  csp_csv_core #(.MS_CYCLES(200)) dut (.core_clk(core_clk), .rstn(rstn), .busReq(busReq),
    .busRdata(busRdata), .syncPulse(syncPulse), .limitPosPin(limitPosPin),
    .limitNegPin(limitNegPin), .actual(actual),
    .demand(demand), .demandValid(demandValid), .quickStopActive(quickStopActive));
  motion_ctrl_model #(.SYNC_GAP(200)) partner (.core_clk(core_clk), .rstn(rstn),
    .syncOn(syncOn), .feOffset(feOffset), .demand(demand), .syncPulse(syncPulse),
    .actual(actual));
  ////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq <= '0;
    #1;
    d = busRdata;
    @(posedge core_clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d & m, e)
  endtask
  // Writes a target once per sync period until demand shows the expected value
  task automatic follow(input logic [7:0] a, input logic signed [31:0] v,
                        input logic signed [31:0] e, input bit useVel);
    int i;
    for (i = 0; i < 8; i++) begin
      wr(a, v);
      repeat (200) @(posedge core_clk);
      if ((useVel ? demand.vel : demand.pos) === e) break;
    end
    `CHK(useVel ? demand.vel : demand.pos, e)
    if (i == 8) tally_and_finish();
  endtask
  ////////////////////////////////////////////////
  // Scenarios
  task automatic tReset();
    rdChk(`REG_STATUS, 32'h00003900, 32'h0);
    rdChk(`REG_IP_INDEX, 32'hffffffff, 32'h000000fd);
    wr(`REG_IP_INDEX, 32'h00000000);
    rdChk(`REG_IP_INDEX, 32'hffffffff, 32'h000000fd);
    rdChk(`REG_IP_PERIOD, 32'hffffffff, 32'h00000001);
    rdChk(`REG_FE_TIMEOUT, 32'hffffffff, 32'h00000064);
    rdChk(8'hfc, 32'hffffffff, 32'h0);
  endtask
  task automatic tPos();
    syncOn <= 1'b1;
    wr(`REG_CONTROL, 32'h00000114);
    wr(`REG_MODE, {24'h0, `MODE_CSP});
    follow(`REG_TARGET_POS, 32'sh4d2, 32'sh4d2, 1'b0);
    rdChk(`REG_STATUS, 32'h00001100, 32'h00001100);
    `CHK(demandValid, 1'b1);
    repeat (600) @(posedge core_clk);
    `CHK(demand.pos, 32'sh4d2);
    rdChk(`REG_ACT_POS, 32'hffffffff, 32'h000004d2);
  endtask
  task automatic tLimits();
    wr(`REG_SWLIM_MAX, 32'h000007d0);
    follow(`REG_TARGET_POS, 32'sh1388, 32'sh7d0, 1'b0);
    rdChk(`REG_STATUS, 32'h00000800, 32'h00000800);
    wr(`REG_SWLIM_MAX, 32'h7fffffff);
    limitPosPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    follow(`REG_TARGET_POS, 32'shbb8, 32'sh7d0, 1'b0);
    limitPosPin <= 1'b0;
    follow(`REG_TARGET_POS, 32'shbb8, 32'shbb8, 1'b0);
    limitNegPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    follow(`REG_TARGET_POS, 32'sh3e8, 32'shbb8, 1'b0);
    limitNegPin <= 1'b0;
    // Range 0..999 wraps a target of 1200 round to 200
    wr(`REG_RANGE_MAX, 32'h000003e7);
    follow(`REG_TARGET_POS, 32'sh4b0, 32'shc8, 1'b0);
    wr(`REG_RANGE_MAX, 32'h00000000);
  endtask
  task automatic tFollowErr();
    logic [31:0] d;
    int          i;
    wr(`REG_FE_TIMEOUT, 32'h00000001);
    feOffset <= 32'sh200;
    rdChk(`REG_STATUS, 32'h00002000, 32'h0);
    for (i = 0; i < 40; i++) begin
      repeat (17) @(posedge core_clk);
      rd(`REG_STATUS, d);
      if (d[13]) break;
    end
    `CHK(d[13], 1'b1);
    // 19 cycles a pass; the flag sets on the third tick, when the counter exceeds a 1 ms timeout
    `CHK(i >= 19, 1'b1);
    if (i == 40) tally_and_finish();
    rdChk(`REG_FE_ACTUAL, 32'hffffffff, 32'hfffffe00);
    feOffset <= 32'sh0;
    repeat (20) @(posedge core_clk);
    rdChk(`REG_STATUS, 32'h00002000, 32'h0);
  endtask
  task automatic tVelQs();
    int i;
    wr(`REG_MODE, {24'h0, `MODE_CSV});
    follow(`REG_TARGET_VEL, 32'sh1f4, 32'sh1f4, 1'b1);
    rdChk(`REG_STATUS, 32'h00001100, 32'h00001100);
    rdChk(`REG_ACT_VEL, 32'hffffffff, 32'h000001f4);
    wr(`REG_QS_DECEL, 32'h00001000);
    wr(`REG_CONTROL, 32'h00000000);
    repeat (10) @(posedge core_clk);
    `CHK(quickStopActive, 1'b1);
    rdChk(`REG_STATUS, 32'h00000020, 32'h00000020);
    for (i = 0; i < 50 && demand.vel !== 32'sh0; i++) begin
      repeat (100) @(posedge core_clk);
    end
    `CHK(demand.vel, 32'sh0);
    if (i == 50) tally_and_finish();
    wr(`REG_CONTROL, 32'h00000004);
    repeat (10) @(posedge core_clk);
    `CHK(quickStopActive, 1'b0);
    // Option 6 keeps the drive in quick-stop after the request is withdrawn
    wr(`REG_QS_OPTION, 32'h00000006);
    wr(`REG_CONTROL, 32'h00000000);
    wr(`REG_CONTROL, 32'h00000004);
    repeat (300) @(posedge core_clk);
    `CHK(quickStopActive, 1'b1);
    wr(`REG_QS_OPTION, 32'h00000002);
    repeat (10) @(posedge core_clk);
    `CHK(quickStopActive, 1'b0);
  endtask
  task automatic tSyncLoss();
    syncOn <= 1'b0;
    repeat (1000) @(posedge core_clk);
    rdChk(`REG_STATUS, 32'h00001100, 32'h0);
    `CHK(demandValid, 1'b0);
  endtask
  ////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn        = 1'b0;
    busReq      = '0;
    limitPosPin = 1'b0;
    limitNegPin = 1'b0;
    syncOn      = 1'b0;
    feOffset    = 32'sh0;
    err_total   = 0;
    n_tests     = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    tReset();
    tPos();
    tLimits();
    tFollowErr();
    tVelQs();
    tSyncLoss();
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
bind csp_csv_core csp_csv_core_properties #(.MS_CYCLES(MS_CYCLES)) chk (.core_clk(core_clk),
  .rstn(rstn), .busReq(busReq), .busRdata(busRdata), .syncPulse(syncPulse),
  .limitPosPin(limitPosPin), .limitNegPin(limitNegPin), .actual(actual), .demand(demand),
  .demandValid(demandValid), .quickStopActive(quickStopActive));
`default_nettype wire

// ---- rtl/csp_csv_consts.svh ----
// Constants for the cyclic synchronous position / velocity block.
// Assumes a 40 MHz core clock and a plain register port.
`ifndef CSP_CSV_CONSTS_SVH
`define CSP_CSV_CONSTS_SVH
// Register offsets
`define REG_MODE        8'h00
`define REG_CONTROL     8'h04
`define REG_STATUS      8'h08
`define REG_TARGET_POS  8'h0c
`define REG_TARGET_VEL  8'h10
`define REG_RANGE_MIN   8'h14
`define REG_RANGE_MAX   8'h18
`define REG_SWLIM_MIN   8'h1c
`define REG_SWLIM_MAX   8'h20
`define REG_FE_WINDOW   8'h24
`define REG_FE_TIMEOUT  8'h28
`define REG_QS_DECEL    8'h2c
`define REG_QS_OPTION   8'h30
`define REG_IP_PERIOD   8'h34
`define REG_IP_INDEX    8'h38
`define REG_ACT_POS     8'h3c
`define REG_ACT_VEL     8'h40
`define REG_FE_ACTUAL   8'h44
`define REG_DEMAND_POS  8'h48
`define REG_DEMAND_VEL  8'h4c
`define REG_SETTINGS    8'h50
// Mode codes
`define MODE_CSP        8'h08
`define MODE_CSV        8'h09
// Status bit positions
`define ST_SYNC         8
`define ST_LIMIT        11
`define ST_FOLLOW       12
`define ST_FERR         13
`define ST_QSACT        5
// Control bit position of quick-stop request (active low in the controlword)
`define CW_QSTOP_N      2
// Time base
`define IP_INDEX_MS     8'hfd
`define CLK_HZ          40000000
`define MS_PER_S        1000
`define CYCLES_PER_MS   (`CLK_HZ / `MS_PER_S)
// Sync loss margin in cycle periods
`define SYNC_MISS_LIMIT 4'h2
// Reset values
`define RST_IP_PERIOD   16'h0001
`define RST_FE_WINDOW   32'h00000100
`define RST_FE_TIMEOUT  16'h0064
`define RST_QS_OPTION   8'h02
`define RST_QS_DECEL    32'h00000400
`endif

// ---- rtl/csp_csv_core.sv ----
// Cyclic synchronous position and velocity control core.
// Assumes one 40 MHz clock; sync and limit switch pins are asynchronous.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "csp_csv_consts.svh"
`default_nettype none
module csp_csv_core #(
  // Core clock cycles in one millisecond of the cycle time base
  parameter int unsigned MS_CYCLES = `CYCLES_PER_MS
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire csp_csv_pkg::bus_req_type  busReq,
  output logic [31:0]                    busRdata,
  input  wire logic                      syncPulse,
  input  wire logic                      limitPosPin,
  input  wire logic                      limitNegPin,
  input  wire csp_csv_pkg::drive_type    actual,
  output csp_csv_pkg::drive_type         demand,
  output logic                           demandValid,
  output logic                           quickStopActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0]         modeObj;
  logic [15:0]        controlWord;
  logic signed [31:0] targetPos;
  logic signed [31:0] targetVel;
  logic signed [31:0] rangeMin;
  logic signed [31:0] rangeMax;
  logic signed [31:0] swLimMin;
  logic signed [31:0] swLimMax;
  logic [31:0]        feWindow;
  logic [15:0]        feTimeout;
  logic [31:0]        qsDecel;
  logic [7:0]         qsOption;
  logic [15:0]        ipPeriod;
  logic [7:0]         ipIndex;
  logic               posWritten;
  logic               velWritten;

  // Write strobe decode for the fresh-target flags
  wire wrTPos   = busReq.wr && busReq.addr == `REG_TARGET_POS;
  wire wrTVel   = busReq.wr && busReq.addr == `REG_TARGET_VEL;

  // Software register writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modeObj     <= 8'h00;
      controlWord <= 16'h0004;
      targetPos   <= 32'h00000000;
      targetVel   <= 32'h00000000;
      rangeMin    <= 32'h00000000;
      rangeMax    <= 32'h00000000;
      swLimMin    <= 32'h80000000;
      swLimMax    <= 32'h7fffffff;
      feWindow    <= `RST_FE_WINDOW;
      feTimeout   <= `RST_FE_TIMEOUT;
      qsDecel     <= `RST_QS_DECEL;
      qsOption    <= `RST_QS_OPTION;
      ipPeriod    <= `RST_IP_PERIOD;
      ipIndex     <= `IP_INDEX_MS;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        `REG_MODE:       modeObj     <= busReq.wdata[7:0];
        `REG_CONTROL:    controlWord <= busReq.wdata[15:0];
        `REG_TARGET_POS: targetPos   <= busReq.wdata;
        `REG_TARGET_VEL: targetVel   <= busReq.wdata;
        `REG_RANGE_MIN:  rangeMin    <= busReq.wdata;
        `REG_RANGE_MAX:  rangeMax    <= busReq.wdata;
        `REG_SWLIM_MIN:  swLimMin    <= busReq.wdata;
        `REG_SWLIM_MAX:  swLimMax    <= busReq.wdata;
        `REG_FE_WINDOW:  feWindow    <= busReq.wdata;
        `REG_FE_TIMEOUT: feTimeout   <= busReq.wdata[15:0];
        `REG_QS_DECEL:   qsDecel     <= busReq.wdata;
        `REG_QS_OPTION:  qsOption    <= busReq.wdata[7:0];
        `REG_IP_PERIOD:  ipPeriod    <= busReq.wdata[15:0];
        `REG_IP_INDEX: begin
          if (busReq.wdata[7:0] == `IP_INDEX_MS) begin
            ipIndex <= busReq.wdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; controlword bits other than quick-stop are unused here
  wire posMode = modeObj == `MODE_CSP;
  wire velMode = modeObj == `MODE_CSV;
  // Quick-stop is the power state machine's, not a mode bit
  wire qsReq   = !controlWord[`CW_QSTOP_N];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] syncSr;
  logic [1:0] limPSr;
  logic [1:0] limNSr;
  logic       syncPrev;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      syncSr   <= 2'b00;
      limPSr   <= 2'b00;
      limNSr   <= 2'b00;
      syncPrev <= 1'b0;
    end else begin
      syncSr   <= {syncSr[0], syncPulse};
      limPSr   <= {limPSr[0], limitPosPin};
      limNSr   <= {limNSr[0], limitNegPin};
      syncPrev <= syncSr[1];
    end
  end
  // Rising edge of the synchronised sync pin starts a fieldbus cycle
  wire syncEdge = syncSr[1] && !syncPrev;
  wire limPos   = limPSr[1];
  wire limNeg   = limNSr[1];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick from the core clock
  localparam int unsigned MsCount = MS_CYCLES;
  logic [15:0] msDiv;
  wire msTick = msDiv == 16'(MsCount - 1);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      msDiv <= 16'h0000;
    end else if (msTick) begin
      msDiv <= 16'h0000;
    end else begin
      msDiv <= msDiv + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timer: period in ms at index -3, compared with sync arrivals
  logic [15:0] cycMs;
  logic [3:0]  missCnt;
  logic        inSync;
  wire cycEnd = msTick && (cycMs >= ipPeriod - 16'h0001);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cycMs   <= 16'h0000;
      missCnt <= 4'h0;
      inSync  <= 1'b0;
    end else begin
      if (syncEdge) begin
        cycMs <= 16'h0000;
      end else if (cycEnd) begin
        cycMs <= 16'h0000;
      end else if (msTick) begin
        cycMs <= cycMs + 16'h0001;
      end
      if (syncEdge) begin
        missCnt <= 4'h0;
        inSync  <= 1'b1;
      end else if (cycEnd) begin
        if (missCnt >= `SYNC_MISS_LIMIT) begin
          inSync <= 1'b0;
        end else begin
          missCnt <= missCnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fresh-target flags; a write in the same cycle as the consume wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      posWritten <= 1'b0;
      velWritten <= 1'b0;
    end else begin
      posWritten <= wrTPos || (posWritten && !syncEdge);
      velWritten <= wrTVel || (velWritten && !syncEdge);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position limiting: range wrap, then software clamp
  function automatic logic signed [31:0] wrapRange(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [31:0] span;
    span = hi - lo + 32'sd1;
    if (lo >= hi) begin
      wrapRange = v;
    end else if (v > hi) begin
      wrapRange = v - span;
    end else if (v < lo) begin
      wrapRange = v + span;
    end else begin
      wrapRange = v;
    end
  endfunction

  wire signed [31:0] wrappedPos = wrapRange(targetPos, rangeMin, rangeMax);
  wire               overMax    = wrappedPos > swLimMax;
  wire               underMin   = wrappedPos < swLimMin;
  wire signed [31:0] clampedPos = overMax ? swLimMax :
                                  underMin ? swLimMin : wrappedPos;
  wire               limitHit   = overMax || underMin;
  // Switch blocks motion toward the tripped end
  wire               velBlocked = (limPos && targetVel > 0) ||
                                  (limNeg && targetVel < 0);
  wire               posBlocked = (limPos && clampedPos > demand.pos) ||
                                  (limNeg && clampedPos < demand.pos);

  ////////////////////////////////////////////////////////////////////////////
  // Quick-stop sequencer
  csp_csv_pkg::qs_state_type qsState;
  csp_csv_pkg::qs_state_type next_qsState;
  wire velZero = demand.vel == 32'sd0;
  always_comb begin
    next_qsState = qsState;
    unique case (qsState)
      csp_csv_pkg::QS_RUN: begin
        if (qsReq) begin
          next_qsState = csp_csv_pkg::QS_BRAKE;
        end
      end
      csp_csv_pkg::QS_BRAKE: begin
        if (velZero) begin
          next_qsState = csp_csv_pkg::QS_HOLD;
        end
      end
      csp_csv_pkg::QS_HOLD: begin
        // Options 5..7 stay in quick-stop; others leave once released
        if (!qsReq && qsOption < 8'h05) begin
          next_qsState = csp_csv_pkg::QS_RUN;
        end else if (!qsReq && qsOption > 8'h07) begin
          next_qsState = csp_csv_pkg::QS_RUN;
        end
      end
      default: next_qsState = csp_csv_pkg::QS_RUN;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      qsState <= csp_csv_pkg::QS_RUN;
    end else begin
      qsState <= next_qsState;
    end
  end
  wire qsOn = qsState != csp_csv_pkg::QS_RUN;

  // One deceleration step toward zero per millisecond
  function automatic logic signed [31:0] stepToZero(
    input logic signed [31:0] v,
    input logic        [31:0] d
  );
    if (v > $signed(d)) begin
      stepToZero = v - $signed(d);
    end else if (v < -$signed(d)) begin
      stepToZero = v + $signed(d);
    end else begin
      stepToZero = 32'sd0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Demand generation: presets are taken directly at each sync
  logic followPos;
  logic followVel;
  wire  takePos = posMode && inSync && !qsOn && !posBlocked;
  wire  takeVel = velMode && inSync && !qsOn && !velBlocked;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      demand      <= '0;
      demandValid <= 1'b0;
      followPos   <= 1'b0;
      followVel   <= 1'b0;
    end else begin
      followPos   <= takePos;
      followVel   <= takeVel;
      demandValid <= takePos || takeVel;
      if (qsOn && msTick) begin
        demand.vel <= stepToZero(demand.vel, qsDecel);
        demand.pos <= actual.pos;
      end else if (syncEdge && takePos && posWritten) begin
        demand.pos <= clampedPos;
        demand.vel <= 32'sd0;
      end else if (syncEdge && takeVel && velWritten) begin
        demand.vel <= targetVel;
        demand.pos <= actual.pos;
      end else if (syncEdge && (velMode && velBlocked)) begin
        demand.vel <= 32'sd0;
      end
      // No fresh preset: the held demand stays unchanged, except a blocked speed is cleared at sync
    end
  end
  assign quickStopActive = qsOn;

  ////////////////////////////////////////////////////////////////////////////
  // Following-error supervision in milliseconds
  logic [31:0] feActual;
  logic [15:0] feMs;
  logic        feFlag;
  wire signed [31:0] feDiff = demand.pos - actual.pos;
  wire [31:0]        feAbs  = feDiff[31] ? 32'(-feDiff) : 32'(feDiff);
  wire               feOut  = posMode && (feAbs > feWindow);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      feActual <= 32'h00000000;
      feMs     <= 16'h0000;
      feFlag   <= 1'b0;
    end else begin
      feActual <= feDiff;
      if (!feOut) begin
        feMs   <= 16'h0000;
        feFlag <= 1'b0;
      end else if (msTick) begin
        if (feMs > feTimeout) begin
          feFlag <= 1'b1;
        end else begin
          feMs <= feMs + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly
  wire [15:0] statusWord = (16'h0001 << `ST_SYNC) * 16'(inSync)
                         | (16'h0001 << `ST_LIMIT) * 16'(limitHit && posMode)
                         | (16'h0001 << `ST_FOLLOW) * 16'(followPos || followVel)
                         | (16'h0001 << `ST_FERR) * 16'(feFlag)
                         | (16'h0001 << `ST_QSACT) * 16'(qsOn);
  wire [31:0] settings = {12'h000, ipIndex, velWritten, posWritten, limNeg, limPos,
                          8'h00};

  // Read mux, registered one cycle after the strobe
  logic [31:0] rdMux;
  always_comb begin
    unique case (busReq.addr)
      `REG_MODE:       rdMux = {24'h000000, modeObj};
      `REG_CONTROL:    rdMux = {16'h0000, controlWord};
      `REG_STATUS:     rdMux = {16'h0000, statusWord};
      `REG_TARGET_POS: rdMux = targetPos;
      `REG_TARGET_VEL: rdMux = targetVel;
      `REG_RANGE_MIN:  rdMux = rangeMin;
      `REG_RANGE_MAX:  rdMux = rangeMax;
      `REG_SWLIM_MIN:  rdMux = swLimMin;
      `REG_SWLIM_MAX:  rdMux = swLimMax;
      `REG_FE_WINDOW:  rdMux = feWindow;
      `REG_FE_TIMEOUT: rdMux = {16'h0000, feTimeout};
      `REG_QS_DECEL:   rdMux = qsDecel;
      `REG_QS_OPTION:  rdMux = {24'h000000, qsOption};
      `REG_IP_PERIOD:  rdMux = {16'h0000, ipPeriod};
      `REG_IP_INDEX:   rdMux = {24'h000000, ipIndex};
      `REG_ACT_POS:    rdMux = actual.pos;
      `REG_ACT_VEL:    rdMux = actual.vel;
      `REG_FE_ACTUAL:  rdMux = feActual;
      `REG_DEMAND_POS: rdMux = demand.pos;
      `REG_DEMAND_VEL: rdMux = demand.vel;
      `REG_SETTINGS:   rdMux = settings;
      default:         rdMux = 32'h00000000;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busRdata <= 32'h00000000;
    end else if (busReq.rd) begin
      busRdata <= rdMux;
    end else begin
      busRdata <= 32'h00000000;
    end
  end


endmodule
`default_nettype wire

// ---- rtl/csp_csv_pkg.sv ----
// Types for the cyclic synchronous position / velocity block.
// Assumes the constants header is included alongside.
`default_nettype none
package csp_csv_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE_type_unused = 2'b00,
    MODE_POS              = 2'b01,
    MODE_VEL              = 2'b10
  } op_mode_type;

  typedef enum logic [1:0] {
    QS_RUN   = 2'b00,
    QS_BRAKE = 2'b01,
    QS_HOLD  = 2'b10
  } qs_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [31:0] vel;
  } drive_type;
endpackage
`default_nettype wire
